// *** verilog/addr_decode_pkg.sv ***
// Purpose: shared constants and carriers for the cycle space decoder
// Assumes: 10 MHz core clock, synchronous active-high reset
// Notes: control space codes follow the top address nibble
package addr_decode_pkg;
    localparam logic [2:0] CODE_USER_DATA = 3'h1;
    localparam logic [2:0] CODE_USER_PROG = 3'h2;
    localparam logic [2:0] CODE_CONTROL = 3'h3;
    localparam logic [2:0] CODE_SUPV_DATA = 3'h5;
    localparam logic [2:0] CODE_SUPV_PROG = 3'h6;
    localparam logic [2:0] CODE_CPU = 3'h7;
    localparam logic [3:0] NIB_LOW = 4'h0;
    localparam logic [3:0] NIB_ACCEL = 4'he;
    localparam logic [3:0] NIB_HIGH = 4'hf;
    localparam int CTL_NIB_MSB = 31;
    localparam int CTL_NIB_LSB = 28;
    localparam int IO_SEL_MSB = 20;
    localparam int IO_SEL_LSB = 17;
    localparam int VA_BITS = 28;
    localparam int NUM_REQ = 5;
    // request index: lower index wins
    localparam int REQ_NET = 0;
    localparam int REQ_FLUSH = 1;
    localparam int REQ_DISK = 2;
    localparam int REQ_VSLV = 3;
    localparam int REQ_CPU = 4;
    localparam logic [4:0] GRANT_RST = 5'h00;
    localparam logic [31:0] PMAP_RST = 32'h0000_0000;
    localparam logic [31:0] TAG_RST = 32'h0000_0000;
    localparam logic [7:0] SYSEN_RST = 8'h00;
    // page map layout: valid, write, supv, nocache, type[1:0], acc, mod, rsvd, page
    localparam logic [31:0] PMAP_RW_MASK = 32'hff00_0000;
    localparam int PMAP_PFN_BITS = 19;
    // cache tag reserved bits kept as storage only
    localparam logic [31:0] TAG_RSVD_MASK = 32'h3000_0800;

    typedef enum logic [2:0] {
        SP_NONE,
        SP_CPU,
        SP_CONTROL,
        SP_DEVICE,
        SP_ACCEL,
        SP_ERROR
    } space_e;

    typedef struct packed {
        logic valid;
        logic [2:0] cycle_function_code;
        logic [31:0] addr;
    } cycle_s;

    typedef struct packed {
        space_e space;
        logic [3:0] ctl_sel;
        logic [3:0] io_sel;
        logic [27:0] va;
        logic bus_err;
    } decode_s;
endpackage : addr_decode_pkg

// *** verilog/addr_space_decoder.sv ***
// Purpose: sorts cycles into spaces, decodes selects, arbitrates the virtual bus
// Assumes: all inputs come from logic on core_clk_i
// Notes: page map and cache tag words are one-entry holding registers here
`timescale 1ns/1ps
module addr_space_decoder #(
    parameter bit ACCEL_PRESENT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input addr_decode_pkg::cycle_s cpu_cycle_i,
    input wire logic [addr_decode_pkg::NUM_REQ-1:0] bus_req_i,
    input wire logic [31:0] dva_addr_i,
    input wire logic pmap_wr_i,
    input wire logic [31:0] pmap_wdata_i,
    input wire logic tag_wr_i,
    input wire logic [31:0] tag_wdata_i,
    input wire logic sysen_wr_i,
    input wire logic [7:0] sysen_wdata_i,
    output addr_decode_pkg::decode_s decode_o,
    output logic [addr_decode_pkg::NUM_REQ-1:0] bus_grant_o,
    output logic [27:0] xlate_va_o,
    output logic xlate_valid_o,
    output logic [31:0] pmap_rdata_o,
    output logic [31:0] tag_rdata_o,
    output logic [7:0] sysen_rdata_o
);

    // function code to space, independent of address
    function automatic addr_decode_pkg::space_e code_space(input logic [2:0] code);
        addr_decode_pkg::space_e sp;
        sp = addr_decode_pkg::SP_ERROR;
        unique case (code)
            addr_decode_pkg::CODE_CPU: sp = addr_decode_pkg::SP_CPU;
            addr_decode_pkg::CODE_CONTROL: sp = addr_decode_pkg::SP_CONTROL;
            addr_decode_pkg::CODE_USER_DATA,
            addr_decode_pkg::CODE_USER_PROG,
            addr_decode_pkg::CODE_SUPV_DATA,
            addr_decode_pkg::CODE_SUPV_PROG: sp = addr_decode_pkg::SP_DEVICE;
            default: sp = addr_decode_pkg::SP_ERROR;
        endcase
        return sp;
    endfunction : code_space

    // first set bit wins; lower index is higher priority
    function automatic logic [addr_decode_pkg::NUM_REQ-1:0] pick(
        input logic [addr_decode_pkg::NUM_REQ-1:0] req
    );
        logic [addr_decode_pkg::NUM_REQ-1:0] g;
        logic found;
        g = '0;
        found = 1'b0;
        for (int i = 0; i < addr_decode_pkg::NUM_REQ; i++) begin
            if (req[i] && !found) begin
                g[i] = 1'b1;
                found = 1'b1;
            end
        end
        return g;
    endfunction : pick

    addr_decode_pkg::decode_s dec_d;
    addr_decode_pkg::decode_s decode_q;
    logic [addr_decode_pkg::NUM_REQ-1:0] grant_d;
    logic [addr_decode_pkg::NUM_REQ-1:0] grant_q;
    logic [27:0] xlate_va_q;
    logic xlate_valid_q;
    logic [31:0] pmap_q;
    logic [31:0] tag_q;
    logic [7:0] sysen_q;
    logic [3:0] nib;

    assign nib = cpu_cycle_i.addr[addr_decode_pkg::CTL_NIB_MSB:addr_decode_pkg::CTL_NIB_LSB];

    // combinational decode of the cpu cycle
    always_comb begin
        dec_d = '0;
        dec_d.space = addr_decode_pkg::SP_NONE;
        if (cpu_cycle_i.valid) begin
            dec_d.space = code_space(cpu_cycle_i.cycle_function_code);
            if (dec_d.space == addr_decode_pkg::SP_CONTROL) begin
                // only the nibble feeds selection; other bits never reach it
                dec_d.ctl_sel = nib;
            end else if (dec_d.space == addr_decode_pkg::SP_DEVICE) begin
                if (ACCEL_PRESENT) begin
                    if (nib == addr_decode_pkg::NIB_ACCEL) begin
                        dec_d.space = addr_decode_pkg::SP_ACCEL;
                    end else if (nib != addr_decode_pkg::NIB_LOW
                                 && nib != addr_decode_pkg::NIB_HIGH) begin
                        dec_d.space = addr_decode_pkg::SP_ERROR;
                    end
                end
                // without the accelerator the nibble is simply dropped
                dec_d.va = cpu_cycle_i.addr[addr_decode_pkg::VA_BITS-1:0];
                dec_d.io_sel = cpu_cycle_i.addr[addr_decode_pkg::IO_SEL_MSB:
                                                addr_decode_pkg::IO_SEL_LSB];
            end
            dec_d.bus_err = (dec_d.space == addr_decode_pkg::SP_ERROR);
        end
    end

    // decoded result register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            decode_q <= '0;
        end else begin
            decode_q <= dec_d;
        end
    end

    // arbitration for the virtual address bus
    always_comb begin
        grant_d = pick(bus_req_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            grant_q <= addr_decode_pkg::GRANT_RST;
        end else begin
            grant_q <= grant_d;
        end
    end

    // translation feed: granted master's address, accelerator never enters
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            xlate_va_q <= '0;
            xlate_valid_q <= 1'b0;
        end else if (grant_d[addr_decode_pkg::REQ_CPU]) begin
            xlate_va_q <= dec_d.va;
            xlate_valid_q <= (dec_d.space == addr_decode_pkg::SP_DEVICE);
        end else if (|grant_d) begin
            xlate_va_q <= dva_addr_i[addr_decode_pkg::VA_BITS-1:0];
            xlate_valid_q <= 1'b1;
        end else begin
            xlate_valid_q <= 1'b0;
        end
    end

    // page map entry: unimplemented page bits masked on write so they read zero
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pmap_q <= addr_decode_pkg::PMAP_RST;
        end else if (pmap_wr_i) begin
            pmap_q <= pmap_wdata_i & (addr_decode_pkg::PMAP_RW_MASK
                      | ((32'h1 << addr_decode_pkg::PMAP_PFN_BITS) - 32'h1));
        end
    end

    // cache tag word: reserved bits stored, nothing reads them internally
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tag_q <= addr_decode_pkg::TAG_RST;
        end else if (tag_wr_i) begin
            tag_q <= tag_wdata_i;
        end
    end

    // enable bits for optional devices exist regardless of fitting
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sysen_q <= addr_decode_pkg::SYSEN_RST;
        end else if (sysen_wr_i) begin
            sysen_q <= sysen_wdata_i;
        end
    end

    assign decode_o = decode_q;
    assign bus_grant_o = grant_q;
    assign xlate_va_o = xlate_va_q;
    assign xlate_valid_o = xlate_valid_q;
    assign pmap_rdata_o = pmap_q;
    // low tag byte returned as stored; allowed to be undefined
    assign tag_rdata_o = tag_q;
    assign sysen_rdata_o = sysen_q;

    // assertion helper: the four device space codes, listed apart from the decode
    logic dev_code_seen;
    assign dev_code_seen = cpu_cycle_i.valid
                           && cpu_cycle_i.cycle_function_code inside {3'h1, 3'h2, 3'h5, 3'h6};

    property p_code_cpu;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cpu_cycle_i.valid && cpu_cycle_i.cycle_function_code == 3'h7
        |=> decode_o.space == addr_decode_pkg::SP_CPU;
    endproperty
    a_code_cpu: assert property (p_code_cpu) else $error("code seven not cpu space");

    property p_code_ctl;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cpu_cycle_i.valid && cpu_cycle_i.cycle_function_code == 3'h3
        |=> decode_o.space == addr_decode_pkg::SP_CONTROL && decode_o.ctl_sel == $past(nib);
    endproperty
    a_code_ctl: assert property (p_code_ctl) else $error("code three not control");

    property p_code_rsvd;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cpu_cycle_i.valid && cpu_cycle_i.cycle_function_code inside {3'h0, 3'h4}
        |=> decode_o.bus_err;
    endproperty
    a_code_rsvd: assert property (p_code_rsvd) else $error("reserved code accepted");

    property p_prio;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus_req_i[0] |=> bus_grant_o == 5'h01;
    endproperty
    a_prio: assert property (p_prio) else $error("network not first");

    property p_cpu_last;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus_grant_o[4] |-> $past(bus_req_i) == 5'h10;
    endproperty
    a_cpu_last: assert property (p_cpu_last) else $error("cpu granted over master");

    property p_dva_xlate;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (|bus_req_i[3:0]) |=> xlate_valid_o && xlate_va_o == $past(dva_addr_i[27:0]);
    endproperty
    a_dva_xlate: assert property (p_dva_xlate) else $error("master bypassed xlate");

    property p_accel;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        ACCEL_PRESENT && cpu_cycle_i.valid && cpu_cycle_i.cycle_function_code == 3'h5
        && nib == 4'he ##0 bus_req_i == 5'h10
        |=> decode_o.space == addr_decode_pkg::SP_ACCEL && !xlate_valid_o;
    endproperty
    a_accel: assert property (p_accel) else $error("accel not bypassed");

    property p_bad_nib;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        ACCEL_PRESENT && dev_code_seen
        && nib != 4'h0 && nib != 4'he && nib != 4'hf |=> decode_o.bus_err;
    endproperty
    a_bad_nib: assert property (p_bad_nib) else $error("bad nibble accepted");

    property p_pmap_zero;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        pmap_rdata_o[23:19] == 5'h00;
    endproperty
    a_pmap_zero: assert property (p_pmap_zero) else $error("unimplemented pmap bits set");

    property p_tag_rsvd;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        tag_wr_i |=> (tag_rdata_o & 32'h3000_0800) == ($past(tag_wdata_i) & 32'h3000_0800);
    endproperty
    a_tag_rsvd: assert property (p_tag_rsvd) else $error("reserved tag bits lost");

    // decode side: space, selects and the carried address
    property p_code_dev;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        dev_code_seen && (!ACCEL_PRESENT || nib == 4'h0 || nib == 4'hf)
        |=> decode_o.space == addr_decode_pkg::SP_DEVICE && !decode_o.bus_err;
    endproperty
    a_code_dev: assert property (p_code_dev) else $error("device code not device space");

    property p_ctl_clean;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cpu_cycle_i.valid && cpu_cycle_i.cycle_function_code == 3'h3
        |=> decode_o.io_sel == 4'h0 && decode_o.va == 28'h0 && !decode_o.bus_err;
    endproperty
    a_ctl_clean: assert property (p_ctl_clean) else $error("control cycle used low bits");

    property p_io_sel;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        dev_code_seen |=> decode_o.io_sel == $past(cpu_cycle_i.addr[20:17]);
    endproperty
    a_io_sel: assert property (p_io_sel) else $error("io select not from field");

    property p_va_low;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        dev_code_seen |=> decode_o.va == $past(cpu_cycle_i.addr[27:0]);
    endproperty
    a_va_low: assert property (p_va_low) else $error("virtual address not low bits");

    property p_plain_dev;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !ACCEL_PRESENT && dev_code_seen
        |=> decode_o.space == addr_decode_pkg::SP_DEVICE && !decode_o.bus_err;
    endproperty
    a_plain_dev: assert property (p_plain_dev) else $error("top nibble not ignored");

    property p_accel_sel;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        ACCEL_PRESENT && dev_code_seen && nib == 4'he
        |=> decode_o.space == addr_decode_pkg::SP_ACCEL && !decode_o.bus_err;
    endproperty
    a_accel_sel: assert property (p_accel_sel) else $error("nibble e not accelerator");

    property p_nib_ok;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        ACCEL_PRESENT && dev_code_seen
        |=> decode_o.bus_err != ($past(nib) inside {4'h0, 4'he, 4'hf});
    endproperty
    a_nib_ok: assert property (p_nib_ok) else $error("valid nibble set wrong");

    // arbitration side: one owner at a time, fixed order
    property p_grant_onehot;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $onehot0(bus_grant_o);
    endproperty
    a_grant_onehot: assert property (p_grant_onehot) else $error("two bus owners");

    property p_flush_second;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus_req_i[1:0] == 2'h2 |=> bus_grant_o == 5'h02;
    endproperty
    a_flush_second: assert property (p_flush_second) else $error("flush not second");

    property p_disk_third;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus_req_i[2:0] == 3'h4 |=> bus_grant_o == 5'h04;
    endproperty
    a_disk_third: assert property (p_disk_third) else $error("disk not third");

    property p_slave_fourth;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus_req_i[3:0] == 4'h8 |=> bus_grant_o == 5'h08;
    endproperty
    a_slave_fourth: assert property (p_slave_fourth) else $error("slave not fourth");

    property p_accel_bypass;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        decode_o.space == addr_decode_pkg::SP_ACCEL && bus_grant_o[4] |-> !xlate_valid_o;
    endproperty
    a_accel_bypass: assert property (p_accel_bypass) else $error("accel entered xlate");

    property p_dev_xlate;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        decode_o.space == addr_decode_pkg::SP_DEVICE && bus_grant_o[4]
        |-> xlate_valid_o && xlate_va_o == decode_o.va;
    endproperty
    a_dev_xlate: assert property (p_dev_xlate) else $error("device cycle not translated");

    // readback side: stored bits come back as written
    property p_pmap_ctl;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        pmap_wr_i |=> pmap_rdata_o[31:24] == $past(pmap_wdata_i[31:24]);
    endproperty
    a_pmap_ctl: assert property (p_pmap_ctl) else $error("pmap control bits lost");

    property p_pmap_page;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        pmap_wr_i |=> pmap_rdata_o[18:0] == $past(pmap_wdata_i[18:0]);
    endproperty
    a_pmap_page: assert property (p_pmap_page) else $error("pmap page bits lost");

    property p_sysen_store;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        sysen_wr_i |=> sysen_rdata_o == $past(sysen_wdata_i);
    endproperty
    a_sysen_store: assert property (p_sysen_store) else $error("enable bits lost");

    property p_tag_store;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        tag_wr_i |=> tag_rdata_o == $past(tag_wdata_i);
    endproperty
    a_tag_store: assert property (p_tag_store) else $error("tag word not returned");

endmodule : addr_space_decoder

// *** test/dva_master_model.sv ***
// Purpose: direct access masters that request the shared virtual bus
// Assumes: want_i comes from the bench, one clock domain
// Notes: the master with the lowest index puts its address out; an idle bus moves every cycle
`timescale 1ns/1ps
module dva_master_model (
    input wire logic core_clk_i,
    input wire logic [4:0] want_i,
    output logic [4:0] bus_req_o,
    output logic [31:0] dva_addr_o
);
    initial begin
        dva_addr_o = 32'h0000_0000;
    end

    // requests are levels, changed just after the edge
    always @(posedge core_clk_i) begin
        bus_req_o <= want_i;
        if (want_i[3:0] == 4'h0) begin
            dva_addr_o <= ~dva_addr_o; // released lines, so no stale value
        end else begin
            for (int i = 3; i >= 0; i--) begin
                if (want_i[i]) begin
                    dva_addr_o <= {4'(i + 9), 28'h0abc_de0} | 32'(i); // noisy top nibble
                end
            end
        end
    end
endmodule : dva_master_model

// *** test/addr_space_decoder_tb_top.sv ***
// Purpose: directed checks of space sorting, selects, arbitration and readback
// Assumes: outputs are registered and appear one edge after the sampling edge
// Notes: a second decoder without the accelerator shares every input
`timescale 1ns/1ps
module addr_space_decoder_tb_top;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    addr_decode_pkg::cycle_s cyc_q = '0;
    logic [4:0] want = 5'h00;
    logic [4:0] bus_req;
    logic [31:0] dva_addr;
    logic pmap_wr = 1'b0;
    logic tag_wr = 1'b0;
    logic sysen_wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    addr_decode_pkg::decode_s dec;
    addr_decode_pkg::decode_s dec_b;
    logic [4:0] grant;
    logic [27:0] xva;
    logic xval;
    logic [31:0] pmap_rd;
    logic [31:0] tag_rd;
    logic [7:0] sysen_rd;
    int checks = 0;
    int bad_count = 0;
    int cycles = 0;
    int lo;
    logic [31:0] a;
    logic [31:0] v;
    addr_decode_pkg::space_e es;

    // 10 MHz clock
    always #50 core_clk_i = ~core_clk_i;

    dva_master_model i_dva_master_model (.core_clk_i(core_clk_i), .want_i(want),
        .bus_req_o(bus_req), .dva_addr_o(dva_addr));

    addr_space_decoder i_addr_space_decoder (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .cpu_cycle_i(cyc_q), .bus_req_i(bus_req), .dva_addr_i(dva_addr),
        .pmap_wr_i(pmap_wr), .pmap_wdata_i(wdata), .tag_wr_i(tag_wr), .tag_wdata_i(wdata),
        .sysen_wr_i(sysen_wr), .sysen_wdata_i(wdata[7:0]), .decode_o(dec),
        .bus_grant_o(grant), .xlate_va_o(xva), .xlate_valid_o(xval),
        .pmap_rdata_o(pmap_rd), .tag_rdata_o(tag_rd), .sysen_rdata_o(sysen_rd));

    addr_space_decoder #(.ACCEL_PRESENT(1'b0)) i_addr_space_decoder_b (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .cpu_cycle_i(cyc_q), .bus_req_i(bus_req), .dva_addr_i(dva_addr),
        .pmap_wr_i(pmap_wr), .pmap_wdata_i(wdata), .tag_wr_i(tag_wr), .tag_wdata_i(wdata),
        .sysen_wr_i(sysen_wr), .sysen_wdata_i(wdata[7:0]), .decode_o(dec_b),
        .bus_grant_o(), .xlate_va_o(), .xlate_valid_o(),
        .pmap_rdata_o(), .tag_rdata_o(), .sysen_rdata_o());

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // one processor cycle, looked at after the answering edge
    task automatic cyc(input logic [2:0] code, input logic [31:0] addr);
        @(posedge core_clk_i);
        cyc_q <= '{valid: 1'b1, cycle_function_code: code, addr: addr};
        @(posedge core_clk_i);
        #1;
    endtask : cyc

    // hang guard, far above the few hundred cycles needed
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk("space after reset", 32'(addr_decode_pkg::SP_NONE), 32'(dec.space));
        chk("grant after reset", 32'h0, 32'(grant));
        $display("test reset done");
        // every request mix; lowest index wins
        for (int m = 1; m < 32; m++) begin
            @(posedge core_clk_i);
            want <= 5'(m);
            repeat (2) @(posedge core_clk_i);
            #1;
            chk("grant", 32'(m & -m), 32'(grant));
            lo = 4;
            for (int j = 3; j >= 0; j--) begin
                if (m[j]) lo = j;
            end
            if (lo < 4) begin
                chk("dva xlate valid", 32'h1, 32'(xval));
                chk("dva xlate va", 32'(28'h0abc_de0 | 28'(lo)), 32'(xva));
            end
        end
        $display("test arbitration done");
        @(posedge core_clk_i);
        want <= 5'h10;
        for (int f = 0; f < 8; f++) begin
            cyc(3'(f), 32'h0012_3456);
            es = (f == 7) ? addr_decode_pkg::SP_CPU : (f == 3) ? addr_decode_pkg::SP_CONTROL :
                (f == 0 || f == 4) ? addr_decode_pkg::SP_ERROR : addr_decode_pkg::SP_DEVICE;
            chk("code space", 32'(es), 32'(dec.space));
            chk("code bus_err", 32'(f == 0 || f == 4), 32'(dec.bus_err));
        end
        $display("test function codes done");
        for (int n = 0; n < 16; n++) begin
            a = {4'(n), 28'h0a5c3e1};
            cyc(addr_decode_pkg::CODE_SUPV_DATA, a);
            es = (n == 14) ? addr_decode_pkg::SP_ACCEL : (n == 0 || n == 15) ?
                addr_decode_pkg::SP_DEVICE : addr_decode_pkg::SP_ERROR;
            chk("nibble space", 32'(es), 32'(dec.space));
            chk("nibble bus_err", 32'(es == addr_decode_pkg::SP_ERROR), 32'(dec.bus_err));
            chk("cpu xlate valid", 32'(es == addr_decode_pkg::SP_DEVICE), 32'(xval));
            if (es == addr_decode_pkg::SP_DEVICE) begin
                chk("cpu xlate va", 32'(a[27:0]), 32'(xva));
                chk("io select", 32'(a[20:17]), 32'(dec.io_sel));
                chk("decode va", 32'(a[27:0]), 32'(dec.va));
            end
            chk("plain space", 32'(addr_decode_pkg::SP_DEVICE), 32'(dec_b.space));
            chk("plain bus_err", 32'h0, 32'(dec_b.bus_err));
            chk("plain va", 32'(a[27:0]), 32'(dec_b.va));
        end
        $display("test device nibbles done");
        for (int n = 0; n < 16; n++) begin
            for (int k = 0; k < 2; k++) begin
                cyc(addr_decode_pkg::CODE_CONTROL, {4'(n), {28{k[0]}}});
                chk("control space", 32'(addr_decode_pkg::SP_CONTROL), 32'(dec.space));
                chk("control select", 32'(n), 32'(dec.ctl_sel));
            end
        end
        $display("test control selects done");
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 32'hffff_ffff : 32'h3000_0800;
            @(posedge core_clk_i);
            {pmap_wr, tag_wr, sysen_wr} <= 3'h7;
            wdata <= v;
            @(posedge core_clk_i);
            {pmap_wr, tag_wr, sysen_wr} <= 3'h0;
            @(posedge core_clk_i);
            #1;
            chk("page map", v & 32'hff07_ffff, pmap_rd);
            chk("cache tag", v, tag_rd);
            chk("enables", 32'(v[7:0]), 32'(sysen_rd));
        end
        $display("test readback done");
        give_verdict();
    end
endmodule : addr_space_decoder_tb_top
